// >>> pgt_pwm_trigger.sv
// pgt_pwm_trigger: six-channel generator, pin routing and converter-start trigger.
// assumes: Avalon-MM master on sys_clk; conv_done_pulse from the converter on sys_clk;
// ext_start pins and nothing else arrive asynchronously.
// limitation: period and duty bytes act at once, with no shadow load, so a
// write in mid-period can shorten or stretch the running period.
// an external event reaches conv_start_pulse two to three clocks after the pin.
// busy holds until conv_done_pulse; a lost done pulse leaves it set.
//
// How it works
// - period joins low and high byte
// - six channels, each 16-bit duty
// - duty high byte forms upper eight bits
// - pin select bit: zero port, one channel
// - group mode uses shared duty for all
// - prescaler code divides by power of two
// - generator idle until run bit set
// - polarity bit inverts channel output
// - pin route bit switches start pin immediately
// - types 00/01 falling or rising edges
// - types 10/11 period centre or end
// - external disabled: software start only
// - external enabled: software or chosen source
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module pgt_pwm_trigger
  import pgt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [PGT_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PGT_NCH-1:0] gpio_out,
  output logic [PGT_NCH-1:0] pin_out,
  input wire logic ext_start_pin_a,
  input wire logic ext_start_pin_b,
  input wire logic conv_done_pulse,
  output logic conv_start_pulse,
  output logic conv_busy
);

  // bus slave
  // one wait cycle per access; readdata and waitrequest both come from flops
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  wire [7:0] idx = avs_address[PGT_ADDR_W-1:2];
  wire acc_go = (avs_read | avs_write) & wait_ff;
  wire wr_en = avs_write & ~wait_ff & avs_byteenable[0];
  wire [7:0] wbyte = avs_writedata[7:0];

  // registers
  logic [7:0] period_low_ff;
  logic [7:0] period_high_ff;
  logic [7:0] duty_low_ff [PGT_NCH];
  logic [7:0] duty_high_ff [PGT_NCH];
  logic [7:0] shared_low_ff;
  logic [7:0] shared_high_ff;
  logic [7:0] pin_sel_ff;
  pgt_gen_ctl_s gen_ctl_ff;
  logic run_ff;
  logic [7:0] polarity_ff;
  pgt_trig_ctl_s trig_ctl_ff;
  pgt_src_e src_ff;
  logic busy_ff;

  // a write lands only in the cycle waitrequest is low, with lane 0 enabled
  wire hit_plow = wr_en & (idx == PGT_IDX_PERIOD_LOW);
  wire hit_phigh = wr_en & (idx == PGT_IDX_PERIOD_HIGH);
  wire hit_slow = wr_en & (idx == PGT_IDX_SHARED_DUTY_LOW);
  wire hit_shigh = wr_en & (idx == PGT_IDX_SHARED_DUTY_HIGH);
  wire hit_pin = wr_en & (idx == PGT_IDX_PIN_SELECT);
  wire hit_gen1 = wr_en & (idx == PGT_IDX_GEN_CTL_ONE);
  wire hit_gen0 = wr_en & (idx == PGT_IDX_GEN_CTL_ZERO);
  wire hit_pol = wr_en & (idx == PGT_IDX_POLARITY);
  wire hit_trig = wr_en & (idx == PGT_IDX_TRIG_CTL);
  wire hit_src = wr_en & (idx == PGT_IDX_TRIG_SOURCE);
  wire hit_stat = wr_en & (idx == PGT_IDX_CONV_STATUS);
  wire sw_start = hit_stat & wbyte[PGT_BIT_BUSY];

  wire [15:0] period_value = {period_high_ff, period_low_ff};
  wire [15:0] shared_duty = {shared_high_ff, shared_low_ff};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= ~acc_go;
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      period_low_ff <= PGT_RESET_BYTE;
      period_high_ff <= PGT_RESET_BYTE;
      shared_low_ff <= PGT_RESET_BYTE;
      shared_high_ff <= PGT_RESET_BYTE;
    end else begin
      if (hit_plow) period_low_ff <= wbyte;
      if (hit_phigh) period_high_ff <= wbyte;
      if (hit_slow) shared_low_ff <= wbyte;
      if (hit_shigh) shared_high_ff <= wbyte;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_sel_ff <= PGT_RESET_BYTE;
      gen_ctl_ff <= pgt_gen_ctl_s'(PGT_RESET_BYTE);
      run_ff <= 1'b0;
      polarity_ff <= PGT_RESET_BYTE;
      trig_ctl_ff <= pgt_trig_ctl_s'(PGT_RESET_BYTE);
      src_ff <= PGT_SRC_CH0;
    end else begin
      if (hit_pin) pin_sel_ff <= wbyte & PGT_PIN_MASK;
      // gen_ctl_ff bits with no function here (out_mode, brake_en) are stored and read back as written
      if (hit_gen1) gen_ctl_ff <= pgt_gen_ctl_s'(wbyte);
      if (hit_gen0) run_ff <= wbyte[PGT_BIT_RUN];
      if (hit_pol) polarity_ff <= wbyte & PGT_PIN_MASK;
      if (hit_trig) trig_ctl_ff <= pgt_trig_ctl_s'(wbyte & PGT_TRIG_CTL_MASK);
      if (hit_src) src_ff <= pgt_src_e'(wbyte[1:0]);
    end
  end

  // prescaler and counter
  logic [6:0] presc_ff;
  logic [15:0] cnt_ff;
  logic up_ff;
  logic [15:0] nxt_cnt;
  logic nxt_up;
  logic centre_evt;
  logic end_evt;
  logic centre_ff;
  logic end_ff;
  // tick when the low prescale bits of a free counter are all ones
  wire [6:0] presc_mask = 7'((8'h01 << gen_ctl_ff.prescale_sel) - 8'h01);
  wire tick = run_ff & ((presc_ff & presc_mask) == presc_mask);

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_up = up_ff;
    centre_evt = 1'b0;
    end_evt = 1'b0;
    if (!run_ff) begin
      nxt_cnt = PGT_RESET_WORD;
      nxt_up = 1'b1;
    end else if (tick) begin
      if (!gen_ctl_ff.align_type) begin
        nxt_cnt = (cnt_ff >= period_value) ? PGT_RESET_WORD : cnt_ff + PGT_ONE_WORD;
      // centre mode dwells one tick at each turn, where the events fire
      end else if (up_ff) begin
        if (cnt_ff >= period_value) begin
          nxt_up = 1'b0;
          centre_evt = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + PGT_ONE_WORD;
        end
      end else if (cnt_ff == PGT_RESET_WORD) begin
        nxt_up = 1'b1;
        end_evt = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - PGT_ONE_WORD;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      presc_ff <= 7'h00;
      cnt_ff <= PGT_RESET_WORD;
      up_ff <= 1'b1;
      centre_ff <= 1'b0;
      end_ff <= 1'b0;
    end else begin
      // clearing on run low gives every run the same tick phase
      presc_ff <= run_ff ? presc_ff + 7'h01 : 7'h00;
      cnt_ff <= nxt_cnt;
      up_ff <= nxt_up;
      centre_ff <= centre_evt;
      end_ff <= end_evt;
    end
  end

  // channels
  logic [PGT_NCH-1:0] wave_ff;
  logic [PGT_NCH-1:0] wave_prev_ff;
  logic [PGT_NCH-1:0] pin_ff;
  logic [7:0] duty_rd [PGT_NCH];
  logic [7:0] duty_hrd [PGT_NCH];

  // the wave is registered once and the pin once more, so polarity and
  // routing act on a flop and cannot glitch the pin
  genvar ch;
  generate
    for (ch = 0; ch < PGT_NCH; ch++) begin : g_ch
      wire hit_lo = wr_en & (idx == PGT_DUTY_LO_IDX[ch]);
      wire hit_hi = wr_en & (idx == 8'(PGT_IDX_CHAN0_DUTY_HIGH + 8'(ch)));
      wire [15:0] own_duty = {duty_high_ff[ch], duty_low_ff[ch]};
      // group mode: every channel follows the shared pair
      wire [15:0] duty = gen_ctl_ff.group_mode_en ? shared_duty : own_duty;
      wire wave = run_ff & (cnt_ff < duty);
      wire routed = pin_sel_ff[ch] ? (wave_ff[ch] ^ polarity_ff[ch]) : gpio_out[ch];
      assign duty_rd[ch] = duty_low_ff[ch];
      assign duty_hrd[ch] = duty_high_ff[ch];
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          duty_low_ff[ch] <= PGT_RESET_BYTE;
          duty_high_ff[ch] <= PGT_RESET_BYTE;
          wave_ff[ch] <= 1'b0;
          wave_prev_ff[ch] <= 1'b0;
          pin_ff[ch] <= 1'b0;
        end else begin
          if (hit_lo) duty_low_ff[ch] <= wbyte;
          if (hit_hi) duty_high_ff[ch] <= wbyte;
          wave_ff[ch] <= wave;
          wave_prev_ff[ch] <= wave_ff[ch];
          pin_ff[ch] <= routed;
        end
      end
    end
  endgenerate

  // external start pins: two flops each before use
  logic [1:0] pin_a_sync_ff;
  logic [1:0] pin_b_sync_ff;
  logic ext_prev_ff;
  logic route_prev_ff;
  wire ext_start_input = trig_ctl_ff.ext_start_pin_route ? pin_b_sync_ff[1] : pin_a_sync_ff[1];
  // a route swap would look like an edge, so for that one cycle the new pin is
  // compared with itself; a real edge in the same cycle is lost
  wire route_flip = route_prev_ff ^ trig_ctl_ff.ext_start_pin_route;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_a_sync_ff <= 2'b00;
      pin_b_sync_ff <= 2'b00;
      ext_prev_ff <= 1'b0;
      route_prev_ff <= 1'b0;
    end else begin
      pin_a_sync_ff <= {pin_a_sync_ff[0], ext_start_pin_a};
      pin_b_sync_ff <= {pin_b_sync_ff[0], ext_start_pin_b};
      ext_prev_ff <= ext_start_input;
      route_prev_ff <= trig_ctl_ff.ext_start_pin_route;
    end
  end

  // trigger
  logic src_now;
  logic src_prev;
  always_comb begin
    // every source code is legal, so there is no default
    unique case (src_ff)
      PGT_SRC_CH0: begin
        src_now = wave_ff[0];
        src_prev = wave_prev_ff[0];
      end
      PGT_SRC_CH2: begin
        src_now = wave_ff[2];
        src_prev = wave_prev_ff[2];
      end
      PGT_SRC_CH4: begin
        src_now = wave_ff[4];
        src_prev = wave_prev_ff[4];
      end
      PGT_SRC_PIN: begin
        src_now = ext_start_input;
        src_prev = route_flip ? ext_start_input : ext_prev_ff;
      end
    endcase
  end

  // edges of the selected source
  wire src_fall = src_prev & ~src_now;
  wire src_rise = ~src_prev & src_now;

  logic ext_evt;
  always_comb begin
    // centre and end events only come in centre-aligned mode
    unique case (trig_ctl_ff.trigger_type)
      PGT_TRIG_FALL: ext_evt = src_fall;
      PGT_TRIG_RISE: ext_evt = src_rise;
      PGT_TRIG_CENTRE: ext_evt = centre_ff;
      PGT_TRIG_END: ext_evt = end_ff;
    endcase
  end

  // external events count only when enabled and not busy
  wire ext_allowed = trig_ctl_ff.ext_trigger_en & ~busy_ff;
  wire ext_start = ext_allowed & ext_evt;
  wire start_now = sw_start | ext_start;

  // software start ignores enable and busy and restarts the pulse
  logic start_ff;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      // a start in the done cycle wins over the clear
      busy_ff <= start_now | (busy_ff & ~conv_done_pulse);
      start_ff <= start_now;
    end
  end

  // read mux
  // registered one cycle ahead; unmapped indexes read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (acc_go & avs_read) begin
      if (idx == PGT_IDX_PERIOD_LOW) nxt_rdata[7:0] = period_low_ff;
      else if (idx == PGT_IDX_PERIOD_HIGH) nxt_rdata[7:0] = period_high_ff;
      else if (idx == PGT_IDX_SHARED_DUTY_LOW) nxt_rdata[7:0] = shared_low_ff;
      else if (idx == PGT_IDX_SHARED_DUTY_HIGH) nxt_rdata[7:0] = shared_high_ff;
      else if (idx == PGT_IDX_PIN_SELECT) nxt_rdata[7:0] = pin_sel_ff;
      else if (idx == PGT_IDX_GEN_CTL_ONE) nxt_rdata[7:0] = gen_ctl_ff;
      else if (idx == PGT_IDX_GEN_CTL_ZERO) nxt_rdata[PGT_BIT_RUN] = run_ff;
      else if (idx == PGT_IDX_POLARITY) nxt_rdata[7:0] = polarity_ff;
      else if (idx == PGT_IDX_TRIG_CTL) nxt_rdata[7:0] = trig_ctl_ff;
      else if (idx == PGT_IDX_TRIG_SOURCE) nxt_rdata[1:0] = src_ff;
      else if (idx == PGT_IDX_CONV_STATUS) nxt_rdata[PGT_BIT_BUSY] = busy_ff;
      for (int i = 0; i < PGT_NCH; i++) begin
        if (idx == PGT_DUTY_LO_IDX[i]) nxt_rdata[7:0] = duty_rd[i];
        if (idx == 8'(PGT_IDX_CHAN0_DUTY_HIGH + 8'(i))) nxt_rdata[7:0] = duty_hrd[i];
      end
    end
  end

  // every output is a flop
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign pin_out = pin_ff;
  assign conv_start_pulse = start_ff;
  assign conv_busy = busy_ff;

endmodule
`default_nettype wire

// >>> pgt_pkg.sv
// pgt_pkg: register map, field positions, reset values and carriers for the
// six-channel generator with converter-start trigger.
// assumes: one 50 MHz system clock, byte-wide registers on one aligned word each.
package pgt_pkg;

  localparam int PGT_CLK_HZ = 50_000_000;
  localparam int PGT_ADDR_W = 10;
  localparam int PGT_NCH = 6;

  // register index; byte address is four times the index
  localparam logic [7:0] PGT_IDX_CHAN4_DUTY_LOW = 8'hcc;
  localparam logic [7:0] PGT_IDX_PERIOD_LOW = 8'hd9;
  localparam logic [7:0] PGT_IDX_CHAN0_DUTY_LOW = 8'hda;
  localparam logic [7:0] PGT_IDX_CHAN1_DUTY_LOW = 8'hdb;
  localparam logic [7:0] PGT_IDX_CHAN2_DUTY_LOW = 8'hdc;
  localparam logic [7:0] PGT_IDX_CHAN3_DUTY_LOW = 8'hdd;
  localparam logic [7:0] PGT_IDX_PIN_SELECT = 8'hde;
  localparam logic [7:0] PGT_IDX_GEN_CTL_ONE = 8'hdf;
  localparam logic [7:0] PGT_IDX_TRIG_CTL = 8'he1;
  localparam logic [7:0] PGT_IDX_CHAN5_DUTY_LOW = 8'he8;
  localparam logic [7:0] PGT_IDX_PERIOD_HIGH = 8'he9;
  localparam logic [7:0] PGT_IDX_CHAN0_DUTY_HIGH = 8'hea;
  localparam logic [7:0] PGT_IDX_SHARED_DUTY_LOW = 8'hf0;
  localparam logic [7:0] PGT_IDX_SHARED_DUTY_HIGH = 8'hf1;
  localparam logic [7:0] PGT_IDX_GEN_CTL_ZERO = 8'hf2;
  localparam logic [7:0] PGT_IDX_POLARITY = 8'hf3;
  localparam logic [7:0] PGT_IDX_TRIG_SOURCE = 8'hf4;
  localparam logic [7:0] PGT_IDX_CONV_STATUS = 8'hf5;

  localparam logic [7:0] PGT_DUTY_LO_IDX [PGT_NCH] = '{
    8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hcc, 8'he8};

  // field positions
  localparam int PGT_BIT_RUN = 7;
  localparam int PGT_BIT_BUSY = 7;
  localparam int PGT_BIT_GROUP = 5;
  localparam int PGT_BIT_ALIGN = 4;
  localparam int PGT_BIT_PIN_ROUTE = 6;
  localparam int PGT_BIT_EXT_EN = 1;
  localparam logic [7:0] PGT_PIN_MASK = 8'h3f;
  localparam logic [7:0] PGT_TRIG_CTL_MASK = 8'h7f;
  localparam logic [7:0] PGT_SRC_MASK = 8'h03;
  localparam logic [7:0] PGT_RESET_BYTE = 8'h00;
  localparam logic [15:0] PGT_RESET_WORD = 16'h0000;
  localparam logic [15:0] PGT_ONE_WORD = 16'h0001;

  typedef enum logic [1:0] {PGT_TRIG_FALL, PGT_TRIG_RISE, PGT_TRIG_CENTRE, PGT_TRIG_END} pgt_trig_e;
  typedef enum logic [1:0] {PGT_SRC_CH0, PGT_SRC_CH2, PGT_SRC_CH4, PGT_SRC_PIN} pgt_src_e;

  typedef struct packed {
    logic [1:0] out_mode;
    logic group_mode_en;
    logic align_type;
    logic brake_en;
    logic [2:0] prescale_sel;
  } pgt_gen_ctl_s;

  typedef struct packed {
    logic spare;
    logic ext_start_pin_route;
    logic [1:0] conv_clk_div;
    pgt_trig_e trigger_type;
    logic ext_trigger_en;
    logic conv_enable;
  } pgt_trig_ctl_s;

endpackage

// >>> pgt_ext_pins.sv
// pgt_ext_pins: external start source driving both start pins.
// assumes: levels come from the bench; pins move off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module pgt_ext_pins (
  input wire logic [1:0] drive_lvl,
  output logic ext_start_pin_a,
  output logic ext_start_pin_b
);
  // skew keeps edges away from sys_clk, so the synchroniser really works
  assign #7 ext_start_pin_a = drive_lvl[0];
  assign #7 ext_start_pin_b = drive_lvl[1];
endmodule
`default_nettype wire

// >>> pgt_pwm_trigger_chk.sv
// pgt_pwm_trigger_chk: bus answer, start pulse and busy properties.
// assumes: bound into pgt_pwm_trigger; one clock, resetn low clears all.
`timescale 1ns/1ps
`default_nettype none
module pgt_pwm_trigger_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic conv_done_pulse,
  input wire logic conv_start_pulse,
  input wire logic conv_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic acc_done = (avs_read || avs_write) && !avs_waitrequest;
  wire logic wr_done = avs_write && !avs_waitrequest;
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  wait_idle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  read_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  pulse_single_a: assert property (conv_start_pulse |=> !conv_start_pulse)
    else $error("start pulse longer than one cycle");
  busy_start_a: assert property (conv_start_pulse |-> conv_busy)
    else $error("start pulse without busy");
  busy_rise_a: assert property ($rose(conv_busy) |-> conv_start_pulse)
    else $error("busy rose without a start");
  ignore_busy_a: assert property (conv_start_pulse |-> !$past(conv_busy) || $past(wr_done) || $past(wr_done, 2))
    else $error("external start accepted while busy");
  done_clear_a: assert property (conv_done_pulse && !acc_done && !$past(acc_done) |-> ##[1:2] !conv_busy)
    else $error("busy not cleared by done");
endmodule
`default_nettype wire

// >>> pgt_pwm_trigger_bench.sv
// pgt_pwm_trigger_bench: self-checking bench for the generator and trigger.
// assumes: pgt_pkg, the checker and the start pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module pgt_pwm_trigger_bench
  import pgt_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [PGT_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [PGT_NCH-1:0] gpio_out = 6'h00;
  logic [PGT_NCH-1:0] pin_out;
  logic ext_start_pin_a;
  logic ext_start_pin_b;
  logic conv_done_pulse = 1'b0;
  logic conv_start_pulse;
  logic conv_busy;
  logic [1:0] lvl = 2'h3;
  logic [31:0] exp_q[$];
  logic [31:0] e_val;
  logic [7:0] d;
  int mismatches = 0;
  int tests_run = 0;
  int starts = 0;
  int s0, c0, c1;
  logic [7:0] ridx [21] = '{8'hd9, 8'he9, 8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hcc, 8'he8, 8'hea, 8'heb, 8'hec,
    8'hed, 8'hee, 8'hef, 8'hf0, 8'hf1, 8'hde, 8'hdf, 8'he1, 8'hf3, 8'hf4};
  logic [7:0] rmsk [21] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h7f, 8'h3f, 8'h03};

  always #10 sys_clk = ~sys_clk;

  pgt_pwm_trigger pgt_pwm_trigger_i (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .gpio_out, .pin_out,
    .ext_start_pin_a, .ext_start_pin_b, .conv_done_pulse, .conv_start_pulse, .conv_busy);
  pgt_ext_pins pgt_ext_pins_i (.drive_lvl(lvl), .ext_start_pin_a, .ext_start_pin_b);

  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      e_val = exp_q.pop_front();
      `CHK(avs_readdata, e_val)
    end
    if (conv_start_pulse === 1'b1) starts++;
  end

  task automatic end_sim;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // request held until waitrequest is seen low, then one idle edge
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] dat, input logic be);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, dat};
    avs_byteenable <= {3'b000, be};
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    // only the watchdog ends a wait that never gets an answer
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    acc(1'b1, idx, dat, 1'b1);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
    exp_q.push_back({24'h00_0000, ex});
    acc(1'b0, idx, 8'h00, 1'b1);
  endtask

  task automatic cnt(input int cyc);
    c0 = 0;
    c1 = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      c0 += int'(pin_out[0] === 1'b1);
      c1 += int'(pin_out[1] === 1'b1);
    end
  endtask

  task automatic done_pulse;
    conv_done_pulse <= 1'b1;
    @(posedge sys_clk);
    conv_done_pulse <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic chk_st(input int n);
    repeat (60) @(posedge sys_clk);
    `CHK(starts - s0, n)
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h4805));
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 21; i++) rd(ridx[i], 8'h00);
    for (int i = 0; i < 21; i++) begin
      d = 8'($urandom);
      wr(ridx[i], d);
      acc(1'b1, ridx[i], ~d, 1'b0);
      rd(ridx[i], d & rmsk[i]);
    end
    wr(8'hf8, 8'hff);
    rd(8'hf8, 8'h00);
    for (int i = 0; i < 21; i++) wr(ridx[i], 8'h00);
    done_pulse();
    wr(8'hf5, 8'h80);
    rd(8'hf5, 8'h80);
    `CHK(conv_busy, 1'b1)
    done_pulse();
    rd(8'hf5, 8'h00);
    `CHK(conv_busy, 1'b0)
    gpio_out <= 6'($urandom);
    repeat (3) @(posedge sys_clk);
    `CHK(pin_out, gpio_out)
    wr(8'hd9, 8'h09);
    wr(8'hda, 8'h03);
    wr(8'heb, 8'h01);
    wr(8'hf3, 8'h02);
    wr(8'hde, 8'h3f);
    cnt(40);
    `CHK(c0, 0)
    wr(8'hf2, 8'h80);
    for (int k = 0; k < 8; k++) begin
      wr(8'hdf, 8'(k));
      repeat (20 << k) @(posedge sys_clk);
      cnt(40 << k);
      `CHK(c0, 12 << k)
      `CHK(c1, 0)
    end
    wr(8'hdf, 8'h20);
    wr(8'hf0, 8'h05);
    repeat (20) @(posedge sys_clk);
    cnt(40);
    `CHK(c0, 20)
    `CHK(c1, 20)
    wr(8'hf2, 8'h00);
    repeat (4) @(posedge sys_clk);
    cnt(20);
    `CHK(c0 + 20 - c1, 0)
    wr(8'hf4, 8'h03);
    s0 = starts;
    lvl <= 2'h2;
    chk_st(0);
    lvl <= 2'h3;
    wr(8'he1, 8'h02);
    s0 = starts;
    lvl <= 2'h2;
    chk_st(1);
    s0 = starts;
    lvl <= 2'h3;
    repeat (10) @(posedge sys_clk);
    lvl <= 2'h2;
    chk_st(0);
    done_pulse();
    s0 = starts;
    wr(8'he1, 8'h42);
    lvl <= 2'h3;
    repeat (10) @(posedge sys_clk);
    lvl <= 2'h2;
    repeat (30) @(posedge sys_clk);
    lvl <= 2'h0;
    chk_st(1);
    done_pulse();
    s0 = starts;
    wr(8'he1, 8'h46);
    lvl <= 2'h3;
    chk_st(1);
    done_pulse();
    wr(8'hf2, 8'h80);
    for (int s = 0; s < 5; s++) begin
      wr(8'he1, 8'h00);
      // centre and end events only exist in centre-aligned mode
      wr(8'hdf, s < 3 ? 8'h20 : 8'h30);
      wr(8'hf4, 8'(s % 3));
      done_pulse();
      s0 = starts;
      wr(8'he1, 8'h02 | 8'((s < 3 ? s % 2 : s - 1) << 2));
      chk_st(1);
    end
    wr(8'he1, 8'h00);
    done_pulse();
    end_sim();
  end
endmodule
bind pgt_pwm_trigger pgt_pwm_trigger_chk pgt_pwm_trigger_chk_i (.sys_clk, .resetn, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .conv_done_pulse, .conv_start_pulse, .conv_busy);
`default_nettype wire
